// ===== hw/brp_map.svh
// Offsets, field positions, reset values and counts of the read prefetch block.
`ifndef BRP_MAP_SVH
`define BRP_MAP_SVH

// ============================================================================
// Register offsets (byte addresses of whole words).
`define BRP_OFS_PFCTL      8'h40
`define BRP_OFS_DYNCTL     8'h48
`define BRP_OFS_CLS        8'h4C
`define BRP_OFS_SPLIT      8'h50
`define BRP_OFS_STAT       8'h54
`define BRP_MAP_HI_ZERO    24'h000000

// ============================================================================
// Field positions.
`define BRP_MR_SEC_LO      24
`define BRP_MRL_SEC_LO     22
`define BRP_MRM_SEC_LO     20
`define BRP_BCNT_LO        12
`define BRP_MR_PRI_LO      8
`define BRP_MRL_PRI_LO     6
`define BRP_MRM_PRI_LO     4
`define BRP_DYN_LO         2
`define BRP_STAT_DYN_LO    10
`define BRP_STAT_BUSY      16
`define BRP_CFG_REG_LO     2
`define BRP_CFG_DEV_LO     11
`define BRP_CFG_BUS_LO     16

// ============================================================================
// Reset values.
`define BRP_PFCTL_RST      32'h0160_2160
`define BRP_DYN_RST        2'h0
`define BRP_CLS_RST        8'h08
`define BRP_SPLIT_RST      16'h0004
`define BRP_DYNLEN_RST     6'h01

// ============================================================================
// Encodings.
`define BRP_CMD_MR         3'h0
`define BRP_CMD_MRL        3'h1
`define BRP_CMD_MRM        3'h2
`define BRP_CMD_MRD        3'h3
`define BRP_CMD_MRB        3'h4
`define BRP_PF_DWORD       2'h0
`define BRP_PF_FILL        2'h2
`define BRP_CFG_T0         2'h0
`define BRP_CFG_T1         2'h1

// ============================================================================
// Sizes and counts.
`define BRP_BUF_BYTES      10'h200
`define BRP_SECTOR         16'h0080
`define BRP_PIECE_CAP      16'h0200
`define BRP_DWORD          16'h0004
`define BRP_NOSPLIT_KB     16'h0020
`define BRP_MB_BYTES       21'h100000
`define BRP_BE_ALL         4'hF

`endif

// ===== hw/brp_pkg.sv
// Types shared by the read prefetch block and its bench.
package brp_pkg;

   typedef enum logic [0:0] {BRP_IDLE, BRP_RUN} brp_st_e;

   typedef struct packed {
      logic [2:0]  cmd;
      logic        side;
      logic        src_pcix;
      logic        dst_pcix;
      logic        prefetchable;
      logic [3:0]  be;
      logic [31:0] addr;
      logic [15:0] bcnt;
   } brp_req_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] len;
      logic [3:0]  be;
      logic [7:0]  rid;
      logic        pf;
      logic        single;
   } brp_iss_s;

   typedef struct packed {
      logic        valid;
      logic        type0;
      logic        type1;
      logic        fwd;
      logic [5:0]  reg_num;
      logic [4:0]  dev;
      logic [7:0]  bus;
   } brp_cfg_s;

   typedef struct packed {
      logic [31:0] pfctl;
      logic [1:0]  dyn_cfg;
      logic [7:0]  cls;
      logic [15:0] split_kb;
      logic        wr_p;
      logic [7:0]  waddr;
      logic [31:0] rdata;
      logic        ready;
      brp_st_e     st;
      logic        rq_ready;
      logic        src_pcix;
      logic        dst_pcix;
      logic        pf;
      logic        nosplit;
      logic [31:0] addr;
      logic [15:0] remain;
      logic [9:0]  buf_free;
      logic [15:0] outst;
      logic [7:0]  rid;
      logic [5:0]  dyn;
      logic        iss_v;
      brp_iss_s    iss;
      brp_cfg_s    cfg;
   } brp_state_s;

endpackage

// ===== hw/brp_top.sv
// Read prefetch control and configuration type decode with an AHB-Lite register port.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "brp_map.svh"

module brp_top
   import brp_pkg::*;
(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Read request from the originating side.
   input  wire logic        rq_valid,
   input  wire brp_req_s    rq,
   output logic             rq_ready,
   input  wire logic        init_disc,
   // Requests issued to the target side.
   output logic             iss_valid,
   output brp_iss_s         iss,
   input  wire logic        iss_ack,
   // Completion and buffer return.
   input  wire logic        cpl_valid,
   input  wire logic [15:0] cpl_bytes,
   input  wire logic        sect_free,
   // Burst outcome history.
   input  wire logic        burst_done,
   input  wire logic        burst_more,
   input  wire logic        burst_waste,
   // Configuration address phase.
   input  wire logic        cfg_valid,
   input  wire logic [31:0] cfg_ad,
   output brp_cfg_s         cfg_o
);

   brp_state_s q;
   brp_state_s d;

   // =========================================================================
   // Next state.
   always_comb
   begin
      logic        ap;
      logic        map_ok;
      logic [1:0]  mr_mode;
      logic        mrl_fill;
      logic        mrm_fill;
      logic        fill;
      logic        pf;
      logic [15:0] lb;
      logic [15:0] line_left;
      logic [15:0] maxb;
      logic [15:0] dynb;
      logic [15:0] total;
      logic [15:0] piece;
      logic [20:0] mb_left;
      logic        go;
      logic [15:0] freeb;
      ap        = 1'b0;
      map_ok    = 1'b0;
      mr_mode   = `BRP_PF_DWORD;
      mrl_fill  = 1'b0;
      mrm_fill  = 1'b0;
      fill      = 1'b0;
      pf        = 1'b0;
      lb        = `BRP_DWORD;
      line_left = `BRP_DWORD;
      maxb      = `BRP_SECTOR;
      dynb      = `BRP_SECTOR;
      total     = `BRP_DWORD;
      piece     = `BRP_DWORD;
      mb_left   = `BRP_MB_BYTES;
      go        = 1'b0;
      freeb     = 16'h0000;
      d         = q;
      d.ready   = 1'b1;

      // ======================================================================
      // Register writes, data phase of a transfer taken one cycle earlier.
      if (q.wr_p)
      begin
         unique case (q.waddr)
            `BRP_OFS_PFCTL:  d.pfctl = hwdata;
            `BRP_OFS_DYNCTL: d.dyn_cfg = hwdata[`BRP_DYN_LO +: 2];
            `BRP_OFS_CLS:    d.cls = hwdata[7:0];
            `BRP_OFS_SPLIT:  d.split_kb = hwdata[15:0];
            default:         d.pfctl = q.pfctl;
         endcase
      end
      ap      = hsel && htrans[1] && hready;
      map_ok  = (haddr[31:8] == `BRP_MAP_HI_ZERO) && (haddr[1:0] == 2'h0);
      d.wr_p  = ap && hwrite && map_ok;
      d.waddr = haddr[7:0];

      // ======================================================================
      // Settings picked from the side of the originator.
      mr_mode  = rq.side ? q.pfctl[`BRP_MR_SEC_LO +: 2] : q.pfctl[`BRP_MR_PRI_LO +: 2];
      mrl_fill = (rq.side ? q.pfctl[`BRP_MRL_SEC_LO +: 2]
                          : q.pfctl[`BRP_MRL_PRI_LO +: 2]) == `BRP_PF_FILL;
      mrm_fill = (rq.side ? q.pfctl[`BRP_MRM_SEC_LO +: 2]
                          : q.pfctl[`BRP_MRM_PRI_LO +: 2]) == `BRP_PF_FILL;
      maxb     = `BRP_SECTOR << q.pfctl[`BRP_BCNT_LO +: 3];
      lb       = (q.cls == 8'h00) ? `BRP_DWORD : {6'h00, q.cls, 2'h0};
      line_left = lb - (rq.addr[15:0] & (lb - 16'h0001));
      dynb     = 16'(q.dyn) * lb;

      unique case (rq.cmd)
         `BRP_CMD_MR:  pf = rq.prefetchable && (rq.src_pcix || mr_mode != `BRP_PF_DWORD);
         `BRP_CMD_MRL: pf = 1'b1;
         `BRP_CMD_MRM: pf = 1'b1;
         `BRP_CMD_MRB: pf = rq.bcnt > `BRP_DWORD;
         default:      pf = 1'b0;
      endcase
      unique case (rq.cmd)
         `BRP_CMD_MR:  fill = mr_mode == `BRP_PF_FILL;
         `BRP_CMD_MRL: fill = mrl_fill;
         `BRP_CMD_MRM: fill = mrm_fill;
         default:      fill = 1'b0;
      endcase

      if (!pf)
         total = `BRP_DWORD;
      else if (rq.src_pcix)
         total = rq.bcnt;
      else if (fill && q.dyn_cfg != `BRP_DYN_RST && dynb < maxb)
         total = dynb;
      else if (fill)
         total = maxb;
      else
         total = line_left;
      if (pf && !rq.src_pcix && rq.dst_pcix && q.split_kb[15:4] == 12'h000
          && total > {2'h0, q.split_kb[3:0], 10'h000})
         total = {2'h0, q.split_kb[3:0], 10'h000};

      // ======================================================================
      // Request engine.
      if (cpl_valid)
         d.outst = (q.outst > cpl_bytes) ? q.outst - cpl_bytes : 16'h0000;
      if (sect_free)
         d.buf_free = (q.buf_free > `BRP_BUF_BYTES - 10'(`BRP_SECTOR))
                      ? `BRP_BUF_BYTES : q.buf_free + 10'(`BRP_SECTOR);
      if (q.iss_v && iss_ack)
         d.iss_v = 1'b0;

      unique case (q.st)
         BRP_IDLE:
         begin
            if (rq_valid && q.rq_ready)
            begin
               d.st       = BRP_RUN;
               d.rq_ready = 1'b0;
               d.src_pcix = rq.src_pcix;
               d.dst_pcix = rq.dst_pcix;
               d.pf       = pf;
               d.nosplit  = q.split_kb >= `BRP_NOSPLIT_KB;
               d.addr     = rq.addr;
               d.remain   = total;
               d.iss.be   = pf ? `BRP_BE_ALL : rq.be;
            end
         end
         BRP_RUN:
         begin
            if (init_disc && q.pf && !q.src_pcix && !q.dst_pcix)
               d.remain = 16'h0000;
            freeb   = {6'h00, q.buf_free};
            mb_left = `BRP_MB_BYTES - {1'b0, q.addr[19:0]};
            piece   = q.remain;
            if (q.src_pcix && q.dst_pcix && !q.nosplit && piece > `BRP_PIECE_CAP)
               piece = `BRP_PIECE_CAP;
            if (piece > freeb && !(q.src_pcix && q.dst_pcix))
               piece = freeb;
            if (q.dst_pcix && {5'h00, piece} > mb_left)
               piece = mb_left[15:0];
            go = (q.remain != 16'h0000) && !q.iss_v && !(init_disc && d.remain == 16'h0000)
                 && ((q.src_pcix && q.dst_pcix) || freeb >= q.remain
                     || freeb >= `BRP_SECTOR)
                 && !(q.dst_pcix && q.outst != 16'h0000);
            if (go)
            begin
               d.iss_v      = 1'b1;
               d.iss.addr   = q.addr;
               d.iss.len    = piece;
               d.iss.rid    = q.rid;
               d.rid        = q.rid + 8'h01;
               d.iss.pf     = q.pf;
               d.iss.single = !q.pf;
               d.addr       = q.addr + {16'h0000, piece};
               d.remain     = q.remain - piece;
               if (!(q.src_pcix && q.dst_pcix))
                  d.buf_free = d.buf_free - piece[9:0];
               if (q.dst_pcix)
                  d.outst = d.outst + piece;
            end
            else if (q.remain == 16'h0000 && !q.iss_v)
            begin
               d.st       = BRP_IDLE;
               d.rq_ready = 1'b1;
            end
         end
      endcase

      // ======================================================================
      // Dynamic prefetch length, conventional originators only.
      if (burst_done && !q.src_pcix && q.dyn_cfg != `BRP_DYN_RST)
      begin
         if (burst_more && q.dyn != 6'h3F && dynb + lb <= maxb)
            d.dyn = q.dyn + 6'h01;
         else if (burst_waste && !burst_more && q.dyn > `BRP_DYNLEN_RST)
            d.dyn = q.dyn - 6'h01;
      end

      // ======================================================================
      // Configuration address decode.
      d.cfg.valid   = cfg_valid;
      d.cfg.type0   = cfg_valid && cfg_ad[1:0] == `BRP_CFG_T0;
      d.cfg.type1   = cfg_valid && cfg_ad[1:0] == `BRP_CFG_T1;
      d.cfg.fwd     = cfg_valid && cfg_ad[1:0] == `BRP_CFG_T1;
      d.cfg.reg_num = cfg_ad[`BRP_CFG_REG_LO +: 6];
      d.cfg.dev     = cfg_ad[`BRP_CFG_DEV_LO +: 5];
      d.cfg.bus     = cfg_ad[`BRP_CFG_BUS_LO +: 8];

      // ======================================================================
      // Read data, taken from the updated values.
      d.rdata = 32'h0000_0000;
      if (ap && !hwrite && map_ok)
      begin
         unique case (haddr[7:0])
            `BRP_OFS_PFCTL:  d.rdata = d.pfctl;
            `BRP_OFS_DYNCTL: d.rdata[`BRP_DYN_LO +: 2] = d.dyn_cfg;
            `BRP_OFS_CLS:    d.rdata[7:0] = d.cls;
            `BRP_OFS_SPLIT:  d.rdata[15:0] = d.split_kb;
            `BRP_OFS_STAT:
            begin
               d.rdata[9:0]                    = d.buf_free;
               d.rdata[`BRP_STAT_DYN_LO +: 6] = d.dyn;
               d.rdata[`BRP_STAT_BUSY]        = d.st == BRP_RUN;
            end
            default:         d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // =========================================================================
   // State register.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q          <= '0;
         q.pfctl    <= `BRP_PFCTL_RST;
         q.dyn_cfg  <= `BRP_DYN_RST;
         q.cls      <= `BRP_CLS_RST;
         q.split_kb <= `BRP_SPLIT_RST;
         q.ready    <= 1'b1;
         q.st       <= BRP_IDLE;
         q.rq_ready <= 1'b1;
         q.buf_free <= `BRP_BUF_BYTES;
         q.dyn      <= `BRP_DYNLEN_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // =========================================================================
   // Outputs.
   assign hreadyout = q.ready;
   assign hresp     = 1'b0;
   assign hrdata    = q.rdata;
   assign rq_ready  = q.rq_ready;
   assign iss_valid = q.iss_v;
   assign iss       = q.iss;
   assign cfg_o     = q.cfg;

   // =========================================================================
   // Checks.
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_issue;
      $rose(q.iss_v);
   endsequence

   AST_PF_BE: assert property (q.iss_v && q.iss.pf |-> q.iss.be == `BRP_BE_ALL)
      else $error("Prefetchable read without all byte enables.");
   AST_NP_ONE: assert property (s_issue and !q.iss.pf |-> q.iss.len == `BRP_DWORD)
      else $error("Non-prefetchable read not one dword.");
   AST_SPLIT_CAP: assert property (s_issue and (q.src_pcix && q.dst_pcix && !q.nosplit)
      |-> q.iss.len <= `BRP_PIECE_CAP)
      else $error("Split piece above 512 bytes.");
   AST_IN_ORDER: assert property (s_issue and q.dst_pcix |-> $past(q.outst) == 16'h0000)
      else $error("Piece issued before previous completion.");
   AST_NEW_RID: assert property (s_issue |-> q.rid == q.iss.rid + 8'h01)
      else $error("Requester identity not renewed.");
   AST_MB_STOP: assert property (s_issue and q.dst_pcix
      |-> {1'b0, q.iss.addr[19:0]} + {5'h00, q.iss.len} <= `BRP_MB_BYTES)
      else $error("Fetch crosses a 1MB boundary.");
   AST_BUF_FREE: assert property (q.buf_free <= `BRP_BUF_BYTES)
      else $error("Free buffer count out of range.");
   AST_DYN_STEP: assert property (##1 (q.dyn - $past(q.dyn) <= 6'h01
      || $past(q.dyn) - q.dyn <= 6'h01))
      else $error("Dynamic length moved more than one line.");
   AST_TYPE0: assert property (cfg_valid && cfg_ad[1:0] == `BRP_CFG_T0
      |=> cfg_o.type0 && !cfg_o.type1)
      else $error("Type 0 not recognised.");
   AST_TYPE1: assert property (cfg_valid && cfg_ad[1:0] == `BRP_CFG_T1
      |=> cfg_o.type1 && cfg_o.dev == $past(cfg_ad[15:11]))
      else $error("Type 1 or device number wrong.");

endmodule

// ===== test/brp_tgt_model.sv
// Target-side partner model that acks issued pieces and returns completions.
`timescale 1ns/10ps
module brp_tgt_model
   import brp_pkg::*;
(
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Bench controls.
   input  wire logic        slow,
   input  wire logic        cpl_on,
   // Issue side of the block.
   input  wire logic        iss_valid,
   input  wire brp_iss_s    iss,
   output logic             iss_ack,
   output logic             cpl_valid,
   output logic [15:0]      cpl_bytes,
   output logic             sect_free
);
   logic [1:0]  wt_q;
   logic [1:0]  cd_q;
   logic [15:0] cq_q;
   logic [7:0]  sec_q;

   // =========================================================================
   // Ack after a delay, complete the whole piece, then free its sectors.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         iss_ack   <= 1'b0;
         cpl_valid <= 1'b0;
         cpl_bytes <= 16'hFFFF;
         sect_free <= 1'b0;
         wt_q      <= 2'h0;
         cd_q      <= 2'h0;
         cq_q      <= 16'h0000;
         sec_q     <= 8'h00;
      end
      else
      begin
         iss_ack   <= 1'b0;
         cpl_valid <= 1'b0;
         cpl_bytes <= ~cpl_bytes;
         sect_free <= 1'b0;
         if (iss_valid && !iss_ack)
         begin
            if (wt_q >= (slow ? 2'h3 : 2'h0))
            begin
               iss_ack <= 1'b1;
               wt_q    <= 2'h0;
               cq_q    <= iss.len;
               cd_q    <= 2'h2;
            end
            else
               wt_q <= wt_q + 2'h1;
         end
         if (cd_q != 2'h0)
         begin
            cd_q <= cd_q - 2'h1;
            if (cd_q == 2'h1 && cpl_on)
            begin
               cpl_valid <= 1'b1;
               cpl_bytes <= cq_q;
            end
         end
         else if (sec_q != 8'h00)
            sect_free <= 1'b1;
         sec_q <= sec_q
                  + ((iss_valid && !iss_ack && wt_q >= (slow ? 2'h3 : 2'h0))
                     ? 8'((iss.len + 16'h007F) >> 7) : 8'h00)
                  - ((cd_q == 2'h0 && sec_q != 8'h00) ? 8'h01 : 8'h00);
      end
   end
endmodule

// ===== test/test_bridge_read_prefetch_cfg_decode.sv
// Self-checking bench of the read prefetch and configuration decode block.
`timescale 1ns/10ps
`include "brp_map.svh"
module test_bridge_read_prefetch_cfg_decode
   import brp_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, rq_valid, rq_ready, init_disc;
   logic        iss_valid, iss_ack, cpl_valid, sect_free, cfg_valid, slow, cpl_on, fst, iv_q;
   logic        burst_done, burst_more, burst_waste, sgl;
   logic [31:0] haddr, hwdata, hrdata, cfg_ad, tot, nxt, bad, mx, npc, outs, t0, n0, r;
   logic [15:0] cpl_bytes;
   logic [7:0]  rid_l;
   logic [3:0]  be_l;
   logic [2:0]  hsize;
   logic [1:0]  htrans;
   brp_req_s    rq;
   brp_iss_s    iss;
   brp_cfg_s    cfg_o;
   int          num_errors, comparisons;

   // =========================================================================
   // Design and target model.
   brp_top brp_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rq_valid(rq_valid), .rq(rq),
      .rq_ready(rq_ready), .init_disc(init_disc), .iss_valid(iss_valid), .iss(iss),
      .iss_ack(iss_ack), .cpl_valid(cpl_valid), .cpl_bytes(cpl_bytes), .sect_free(sect_free),
      .burst_done(burst_done), .burst_more(burst_more), .burst_waste(burst_waste),
      .cfg_valid(cfg_valid), .cfg_ad(cfg_ad), .cfg_o(cfg_o));
   brp_tgt_model brp_tgt_model_i (.hclk(hclk), .hresetn(hresetn), .slow(slow), .cpl_on(cpl_on),
      .iss_valid(iss_valid), .iss(iss), .iss_ack(iss_ack), .cpl_valid(cpl_valid),
      .cpl_bytes(cpl_bytes), .sect_free(sect_free));

   // =========================================================================
   // Monitor of issued pieces: totals, continuity, identities and ordering.
   always @(posedge hclk)
   begin
      if (rq_valid && rq_ready)
      begin
         fst <= 1'b1;
         mx  <= 32'h0;
      end
      if (iss_valid && iss_ack)
      begin
         fst   <= 1'b0;
         tot   <= tot + {16'h0, iss.len};
         npc   <= npc + 32'h1;
         be_l  <= iss.be;
         sgl   <= iss.single;
         nxt   <= iss.addr + {16'h0, iss.len};
         rid_l <= iss.rid;
         if (iss.len > mx[15:0])
            mx <= {16'h0, iss.len};
         if ((!fst && (iss.addr !== nxt || iss.rid !== rid_l + 8'h01))
             || {1'b0, iss.addr[19:0]} + {5'h00, iss.len} > 21'h100000)
            bad <= bad + 32'h1;
      end
      if (iss_valid && !iv_q && outs != 32'h0)
         bad <= bad + 32'h1;
      outs <= outs + ((iss_valid && iss_ack && cpl_on) ? {16'h0, iss.len} : 32'h0)
              - (cpl_valid ? {16'h0, cpl_bytes} : 32'h0);
      iv_q <= iss_valid;
   end

   // =========================================================================
   // Common tasks.
   task automatic end_sim();
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tmo(input int k, input int lim);
      if (k >= lim)
      begin
         num_errors++;
         end_sim();
      end
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 50)
      begin
         @(posedge hclk);
         k++;
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 50)
      begin
         @(posedge hclk);
         k++;
      end
      r = hrdata;
      tmo(k, 50);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask

   task automatic run(input brp_req_s q, input logic d, input logic [31:0] et, input logic [3:0] eb);
      int k;
      k = 0;
      t0 = tot;
      n0 = npc;
      rq <= q;
      rq_valid <= 1'b1;
      cpl_on <= q.dst_pcix;
      @(posedge hclk);
      while (rq_ready !== 1'b1 && k < 50)
      begin
         @(posedge hclk);
         k++;
      end
      rq_valid <= 1'b0;
      init_disc <= d;
      @(posedge hclk);
      init_disc <= 1'b0;
      while (rq_ready !== 1'b1 && k < 3000)
      begin
         @(posedge hclk);
         k++;
      end
      repeat (12) @(posedge hclk);
      tmo(k, 3000);
      chk(tot - t0, et);
      chk({28'h0, be_l}, {28'h0, eb});
      chk(bad, 32'h0);
   endtask

   // =========================================================================
   // Scenarios.
   task automatic t_regs();
      rdc(`BRP_OFS_PFCTL, `BRP_PFCTL_RST);
      rdc(`BRP_OFS_DYNCTL, 32'h0);
      rdc(`BRP_OFS_CLS, 32'h0000_0008);
      rdc(`BRP_OFS_SPLIT, 32'h0000_0004);
      ahb(1'b1, `BRP_OFS_STAT, 32'hFFFF_FFFF);
      rdc(`BRP_OFS_STAT, 32'h0000_0600);
      ahb(1'b1, 32'h0000_005C, 32'h1234_5678);
      rdc(32'h0000_005C, 32'h0);
   endtask

   task automatic t_cfg();
      logic [31:0] cad [4];
      cad = '{32'h0000_07A4, 32'h0000_00A4, 32'h0012_7B31, 32'h0012_7B32};
      foreach (cad[i])
      begin
         cfg_valid <= 1'b1;
         cfg_ad <= cad[i];
         @(posedge hclk);
         cfg_valid <= 1'b0;
         @(posedge hclk);
         chk({cfg_o.valid, cfg_o.type0, cfg_o.type1, cfg_o.fwd, cfg_o.reg_num}, {1'b1, cad[i][1:0] == 2'h0, cad[i][1:0] == 2'h1, cad[i][1:0] == 2'h1, cad[i][7:2]});
         if (cad[i][1:0] == 2'h1)
            chk({cfg_o.dev, cfg_o.bus}, {cad[i][15:11], cad[i][23:16]});
      end
   endtask

   task automatic t_reads();
      run('{`BRP_CMD_MR, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 32'h1008, 16'h0}, 1'b0, 32'h4, 4'h3);
      chk({31'h0, sgl}, 32'h1);
      run('{`BRP_CMD_MRD, 1'b0, 1'b1, 1'b0, 1'b1, 4'h5, 32'h1100, 16'h4}, 1'b0, 32'h4, 4'h5);
      run('{`BRP_CMD_MR, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 32'h1010, 16'h0}, 1'b0, 32'h10, 4'hF);
      run('{`BRP_CMD_MRL, 1'b1, 1'b0, 1'b0, 1'b1, 4'h8, 32'h2004, 16'h0}, 1'b0, 32'h1C, 4'hF);
      run('{`BRP_CMD_MRM, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 32'h3000, 16'h0}, 1'b0, 32'h200, 4'hF);
      ahb(1'b1, `BRP_OFS_PFCTL, 32'h0160_3160);
      rdc(`BRP_OFS_PFCTL, 32'h0160_3160);
      slow <= 1'b1;
      run('{`BRP_CMD_MRM, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 32'h4000, 16'h0}, 1'b0, 32'h400, 4'hF);
      chk({31'h0, mx <= 32'h200}, 32'h1);
      slow <= 1'b0;
      run('{`BRP_CMD_MRM, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 32'h5000, 16'h0}, 1'b1, 32'h0, 4'hF);
      run('{`BRP_CMD_MRM, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 32'h5000, 16'h0}, 1'b0, 32'h400, 4'hF);
   endtask

   task automatic t_pcix();
      run('{`BRP_CMD_MRB, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 32'h8000, 16'h0400}, 1'b0, 32'h400, 4'hF);
      chk(npc - n0, 32'h2);
      chk(mx, 32'h200);
      ahb(1'b1, `BRP_OFS_SPLIT, 32'h0000_0020);
      run('{`BRP_CMD_MRB, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 32'h9000, 16'h0400}, 1'b0, 32'h400, 4'hF);
      chk(npc - n0, 32'h1);
      run('{`BRP_CMD_MRB, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 32'hA000, 16'h0300}, 1'b0, 32'h300, 4'hF);
      run('{`BRP_CMD_MRM, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 32'hC000, 16'h0}, 1'b1, 32'h400, 4'hF);
      run('{`BRP_CMD_MRM, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 32'h000F_FF80, 16'h0}, 1'b0, 32'h400, 4'hF);
   endtask

   task automatic t_dyn();
      ahb(1'b1, `BRP_OFS_DYNCTL, 32'h0000_0004);
      rdc(`BRP_OFS_DYNCTL, 32'h0000_0004);
      burst_done <= 1'b1;
      burst_more <= 1'b1;
      @(posedge hclk);
      burst_done <= 1'b0;
      burst_more <= 1'b0;
      ahb(1'b0, `BRP_OFS_STAT, 32'h0);
      chk({25'h0, r[16:10]}, 32'h2);
      burst_done <= 1'b1;
      burst_waste <= 1'b1;
      @(posedge hclk);
      burst_done <= 1'b0;
      burst_waste <= 1'b0;
      ahb(1'b0, `BRP_OFS_STAT, 32'h0);
      chk({25'h0, r[16:10]}, 32'h1);
   endtask

   // =========================================================================
   // Clock, reset and main sequence.
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   initial
   begin
      {hresetn, hsel, hwrite, rq_valid, init_disc, cfg_valid, slow, cpl_on} = 8'h00;
      {burst_done, burst_more, burst_waste, fst, iv_q, sgl} = 6'h00;
      {haddr, hwdata, cfg_ad, tot, nxt, bad, mx, npc, outs} = '0;
      {hsize, htrans, rid_l, be_l} = '0;
      rq = '0;
      num_errors = 0;
      comparisons = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_cfg();
      t_reads();
      t_pcix();
      t_dyn();
      end_sim();
   end
endmodule
